// ---- rtl/t2fbs_top.sv ----
/*
  second 16-bit timer: overflow and trigger-edge flags, capture/reload, and
  serial receive/transmit clock source selection.
  assumes the core drives flag clears and control bits on CLK_I; the trigger
  pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - overflow sets flag unless serial select active
// - pin fall capture/reload sets edge flag
// - receive clock select chooses timer overflow
// - transmit clock select chooses timer overflow
// - serial select forces auto-reload on overflow
// - capture mode latches timer on pin fall
module t2fbs_top #(
  parameter int WIDTH = t2fbs_pkg::TMR_WIDTH
) (
  // clock and reset
  input  wire logic             CLK_I,
  input  wire logic             NRST_I,
  // timer control
  input  wire logic             RUN_I,
  input  wire logic             CAPTURE_NOT_RELOAD_SEL_I,
  input  wire logic             TRIGGER_PIN_ENABLE_I,
  input  wire logic             CAPTURE_RELOAD_TRIGGER_PIN_I,
  input  wire logic             RELOAD_WR_I,
  input  wire logic [WIDTH-1:0] RELOAD_DATA_I,
  // flag clears from software
  input  wire logic             OVF_FLAG_CLR_I,
  input  wire logic             EDGE_FLAG_CLR_I,
  // serial clock selection
  input  wire logic             RX_CLOCK_SOURCE_SEL_I,
  input  wire logic             TX_CLOCK_SOURCE_SEL_I,
  input  wire logic [1:0]       SERIAL_MODE_I,
  input  wire logic             TIMER1_OVF_I,
  // status and outputs
  output logic                  TIMER_TWO_OVERFLOW_FLAG_O,
  output logic                  TRIGGER_EDGE_FLAG_O,
  output logic [WIDTH-1:0]      COUNT_O,
  output logic [WIDTH-1:0]      CAPTURE_RELOAD_O,
  output logic                  RX_BAUD_TICK_O,
  output logic                  TX_BAUD_TICK_O
);
  // refuse widths at elaboration; the all-ones compare cannot serve a wider count
  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("t2fbs_top: WIDTH must lie in 2..16");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] crl;
    logic [1:0]       pre;
    logic             ovf_flag;
    logic             edge_flag;
    logic             rx_tick;
    logic             tx_tick;
  } t2fbs_state_t;

  t2fbs_state_t st_q, st_d;
  t2fbs_pkg::t2fbs_mode_t mode;
  logic fall;
  logic serial_sel;
  logic serial_mode;
  logic step;
  logic ovf;
  logic trig;

  t2fbs_edge i_t2fbs_edge (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .pin_i  (CAPTURE_RELOAD_TRIGGER_PIN_I),
    .fall_o (fall)
  );

  assign serial_sel  = RX_CLOCK_SOURCE_SEL_I | TX_CLOCK_SOURCE_SEL_I;
  assign serial_mode = (SERIAL_MODE_I == t2fbs_pkg::MODE_1) ||
                       (SERIAL_MODE_I == t2fbs_pkg::MODE_3);
  // timer mode counts once every two system clocks
  assign step = RUN_I && (st_q.pre == t2fbs_pkg::PRESCALE_LAST);
  assign ovf  = step && (st_q.cnt == WIDTH'(t2fbs_pkg::TMR_MAX));
  assign trig = fall && TRIGGER_PIN_ENABLE_I;

  always_comb begin
    if (serial_sel) begin
      mode = t2fbs_pkg::T2FBS_BAUD;
    end else if (CAPTURE_NOT_RELOAD_SEL_I) begin
      mode = t2fbs_pkg::T2FBS_CAPTURE;
    end else begin
      mode = t2fbs_pkg::T2FBS_RELOAD;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.pre = RUN_I ? (step ? 2'h0 : st_q.pre + 2'h1) : 2'h0;
    if (RELOAD_WR_I) begin
      st_d.crl = RELOAD_DATA_I;
    end
    if (step) begin
      st_d.cnt = st_q.cnt + WIDTH'(t2fbs_pkg::TMR_ONE);
    end
    case (mode)
      t2fbs_pkg::T2FBS_BAUD: begin
        if (ovf) begin
          st_d.cnt = st_q.crl;
        end
      end
      t2fbs_pkg::T2FBS_CAPTURE: begin
        if (trig) begin
          st_d.crl = st_q.cnt;
        end
      end
      t2fbs_pkg::T2FBS_RELOAD: begin
        if (ovf || trig) begin
          st_d.cnt = st_q.crl;
        end
      end
      default: begin
        st_d.cnt = st_q.cnt;
      end
    endcase
    // the set wins over a clear arriving in the same cycle
    if (OVF_FLAG_CLR_I) begin
      st_d.ovf_flag = 1'h0;
    end
    if (ovf && !serial_sel) begin
      st_d.ovf_flag = 1'h1;
    end
    if (EDGE_FLAG_CLR_I) begin
      st_d.edge_flag = 1'h0;
    end
    // in baud mode the pin no longer reloads, but it still flags
    if (trig) begin
      st_d.edge_flag = 1'h1;
    end
    if (RX_CLOCK_SOURCE_SEL_I == t2fbs_pkg::SEL_TIMER2) begin
      st_d.rx_tick = serial_mode && ovf;
    end else begin
      st_d.rx_tick = serial_mode && TIMER1_OVF_I;
    end
    if (TX_CLOCK_SOURCE_SEL_I == t2fbs_pkg::SEL_TIMER2) begin
      st_d.tx_tick = serial_mode && ovf;
    end else begin
      st_d.tx_tick = serial_mode && TIMER1_OVF_I;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_q <= '{cnt: WIDTH'(t2fbs_pkg::TMR_RST), crl: WIDTH'(t2fbs_pkg::TMR_RST),
                pre: 2'h0, ovf_flag: 1'h0, edge_flag: 1'h0, rx_tick: 1'h0,
                tx_tick: 1'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign TIMER_TWO_OVERFLOW_FLAG_O = st_q.ovf_flag;
  assign TRIGGER_EDGE_FLAG_O       = st_q.edge_flag;
  assign COUNT_O                   = st_q.cnt;
  assign CAPTURE_RELOAD_O          = st_q.crl;
  assign RX_BAUD_TICK_O            = st_q.rx_tick;
  assign TX_BAUD_TICK_O            = st_q.tx_tick;

  a_ovf_flag_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    ovf && !serial_sel |=> TIMER_TWO_OVERFLOW_FLAG_O)
    else $error("overflow did not set flag");
  a_ovf_flag_baud: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    serial_sel && !TIMER_TWO_OVERFLOW_FLAG_O && !(ovf && !serial_sel)
    |=> !TIMER_TWO_OVERFLOW_FLAG_O)
    else $error("overflow flag rose in baud mode");
  a_ovf_flag_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    TIMER_TWO_OVERFLOW_FLAG_O && !OVF_FLAG_CLR_I |=> TIMER_TWO_OVERFLOW_FLAG_O)
    else $error("overflow flag cleared without software");
  a_edge_flag_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    trig |=> TRIGGER_EDGE_FLAG_O)
    else $error("trigger edge did not set flag");
  a_edge_flag_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    TRIGGER_EDGE_FLAG_O && !EDGE_FLAG_CLR_I |=> TRIGGER_EDGE_FLAG_O)
    else $error("edge flag cleared without software");
  a_rx_tick_src: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    serial_mode && RX_CLOCK_SOURCE_SEL_I && ovf |=> RX_BAUD_TICK_O)
    else $error("receive tick missed timer two overflow");
  a_tx_tick_src: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    serial_mode && !TX_CLOCK_SOURCE_SEL_I |=> TX_BAUD_TICK_O == $past(TIMER1_OVF_I))
    else $error("transmit tick not from timer one");
  a_baud_reload: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    serial_sel && ovf && !RELOAD_WR_I |=> COUNT_O == $past(CAPTURE_RELOAD_O))
    else $error("baud mode did not auto-reload");
  a_capture_val: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !serial_sel && CAPTURE_NOT_RELOAD_SEL_I && trig && !RELOAD_WR_I
    |=> CAPTURE_RELOAD_O == $past(COUNT_O))
    else $error("capture did not latch count");

  c_overflow: cover property (@(posedge CLK_I) disable iff (!NRST_I) ovf && !serial_sel);
  c_capture: cover property (@(posedge CLK_I) disable iff (!NRST_I)
    trig && mode == t2fbs_pkg::T2FBS_CAPTURE);
  c_baud_tick: cover property (@(posedge CLK_I) disable iff (!NRST_I) RX_BAUD_TICK_O);
  c_set_clear: cover property (@(posedge CLK_I) disable iff (!NRST_I) ovf && OVF_FLAG_CLR_I);
endmodule : t2fbs_top
`default_nettype wire

// ---- common/t2fbs_pkg.sv ----
/*
  constants for the second timer's flag and serial clock select block.
  assumes a single system clock domain; no register bus, all bits are ports.
*/
package t2fbs_pkg;
  localparam int          TMR_WIDTH   = 16;
  localparam logic [15:0] TMR_RST     = 16'h0000;
  localparam logic [15:0] TMR_MAX     = 16'hFFFF;
  localparam logic [15:0] TMR_ONE     = 16'h0001;
  localparam logic [1:0]  MODE_1      = 2'h1;
  localparam logic [1:0]  MODE_3      = 2'h3;
  localparam logic [1:0]  PRESCALE_LAST = 2'h1;
  localparam logic        SEL_TIMER1  = 1'h0;
  localparam logic        SEL_TIMER2  = 1'h1;

  typedef enum logic [1:0] {
    T2FBS_IDLE    = 2'b00,
    T2FBS_RELOAD  = 2'b01,
    T2FBS_CAPTURE = 2'b10,
    T2FBS_BAUD    = 2'b11
  } t2fbs_mode_t;
endpackage : t2fbs_pkg

// ---- rtl/t2fbs_edge.sv ----
/*
  two-flop synchroniser with falling edge detect for an external pin.
  assumes the pin is asynchronous to CLK_I; the edge pulse lags the pin by 2 edges.
*/
`timescale 1ns/1ps
`default_nettype none
module t2fbs_edge (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic pin_i,
  output logic      fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } t2fbs_edge_t;

  t2fbs_edge_t st_q, st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '{s1: 1'h1, s2: 1'h1, s3: 1'h1};
    end else begin
      st_q <= st_d;
    end
  end

  // only the second and third stages feed the detector
  assign fall_o = st_q.s3 & ~st_q.s2;
endmodule : t2fbs_edge
`default_nettype wire

// ---- verification/t2fbs_serial_model.sv ----
/* serial port stand-in: makes timer1 overflow pulses and counts baud ticks.
   assumes one clock shared with the timer block. */
`timescale 1ns/1ps
`default_nettype none
module t2fbs_serial_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // baud ticks in, timer1 overflow out
  input  wire logic rx_tick_i,
  input  wire logic tx_tick_i,
  output logic      t1_ovf_o,
  output int        rx_cnt_o,
  output int        tx_cnt_o
);
  logic [2:0] div_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q    <= 3'h0;
      rx_cnt_o <= 0;
      tx_cnt_o <= 0;
    end else begin
      div_q    <= div_q + 3'h1;
      rx_cnt_o <= rx_cnt_o + int'(rx_tick_i);
      tx_cnt_o <= tx_cnt_o + int'(tx_tick_i);
    end
  end
  // fixed 8-clock period so any 64-clock window holds exactly 8 pulses
  assign t1_ovf_o = (div_q == 3'h7);
endmodule : t2fbs_serial_model
`default_nettype wire

// ---- verification/tb_timer2_flags_baud_select.sv ----
/* bench for the timer2 flags and baud source select block.
   assumes the serial model pulses timer1 overflow every 8 clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb_timer2_flags_baud_select;
  logic        clk, nrst, run, cap, en, pin, wr, oclr, eclr, rxs, txs, t1, ovf, edg, rxt, txt;
  logic [1:0]  mode;
  logic [15:0] rdat, cnt, crv, exp_tk;
  int          rxc, txc, n_errors, check_count, r0, t0, i;
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  t2fbs_top i_t2fbs_top (.CLK_I(clk), .NRST_I(nrst), .RUN_I(run),
    .CAPTURE_NOT_RELOAD_SEL_I(cap), .TRIGGER_PIN_ENABLE_I(en),
    .CAPTURE_RELOAD_TRIGGER_PIN_I(pin), .RELOAD_WR_I(wr), .RELOAD_DATA_I(rdat),
    .OVF_FLAG_CLR_I(oclr), .EDGE_FLAG_CLR_I(eclr), .RX_CLOCK_SOURCE_SEL_I(rxs),
    .TX_CLOCK_SOURCE_SEL_I(txs), .SERIAL_MODE_I(mode), .TIMER1_OVF_I(t1),
    .TIMER_TWO_OVERFLOW_FLAG_O(ovf), .TRIGGER_EDGE_FLAG_O(edg), .COUNT_O(cnt),
    .CAPTURE_RELOAD_O(crv), .RX_BAUD_TICK_O(rxt), .TX_BAUD_TICK_O(txt));
  t2fbs_serial_model i_t2fbs_serial_model (.clk_i(clk), .nrst_i(nrst), .rx_tick_i(rxt),
    .tx_tick_i(txt), .t1_ovf_o(t1), .rx_cnt_o(rxc), .tx_cnt_o(txc));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic wr_reload(input logic [15:0] d);
    rdat = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reload
  // the pin is synchronised, so hold it low well past the 2-edge lag
  task automatic pin_fall;
    pin = 1'b0;
    repeat (6) @(negedge clk);
    pin = 1'b1;
    repeat (2) @(negedge clk);
  endtask : pin_fall
  task automatic clr;
    oclr = 1'b1;
    eclr = 1'b1;
    @(negedge clk);
    oclr = 1'b0;
    eclr = 1'b0;
    @(negedge clk);
  endtask : clr
  initial begin
    {nrst, run, wr, oclr, eclr, rxs, txs} = 7'h00;
    {cap, en, pin} = 3'h7;
    mode = 2'h0;
    rdat = 16'h0000;
    n_errors = 0;
    check_count = 0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk("count rst", 16'h0000, cnt);
    wr_reload(16'h1234);
    chk("reload reg", 16'h1234, crv);
    pin_fall;
    chk("capture", 16'h0000, crv);
    chk("edge flag", 16'h0001, {15'h0, edg});
    clr;
    chk("edge clr", 16'h0000, {15'h0, edg});
    en = 1'b0;
    pin_fall;
    chk("edge off", 16'h0000, {15'h0, edg});
    en = 1'b1;
    cap = 1'b0;
    wr_reload(16'hFFF0);
    pin_fall;
    chk("pin reload", 16'hFFF0, cnt);
    chk("edge reload", 16'h0001, {15'h0, edg});
    // capture a nonzero count over a different register value
    cap = 1'b1;
    wr_reload(16'h1234);
    pin_fall;
    chk("capture count", 16'hFFF0, crv);
    cap = 1'b0;
    clr;
    run = 1'b1;
    for (i = 0; i < 40 && ovf !== 1'b1; i++) @(negedge clk);
    if (i == 40) begin
      n_errors++;
      wrap_up;
    end
    chk("ovf reload", 16'hFFF0, cnt);
    repeat (3) @(negedge clk);
    chk("ovf sticky", 16'h0001, {15'h0, ovf});
    // next overflow comes 32 clocks after the last; clear on that very edge
    repeat (28) @(negedge clk);
    oclr = 1'b1;
    @(negedge clk);
    oclr = 1'b0;
    chk("ovf set wins", 16'h0001, {15'h0, ovf});
    for (int s = 1; s >= 0; s--) begin
      // capture select set while baud sourcing must still reload
      cap = s[0];
      rxs = s[0];
      txs = s[0];
      clr;
      for (int m = 0; m < 4; m++) begin
        mode = m[1:0];
        repeat (4) @(negedge clk);
        r0 = rxc;
        t0 = txc;
        repeat (64) @(negedge clk);
        exp_tk = m[0] ? (s[0] ? 16'h0002 : 16'h0008) : 16'h0000;
        chk("rx ticks", exp_tk, 16'(rxc - r0));
        chk("tx ticks", exp_tk, 16'(txc - t0));
      end
      chk("ovf flag", {15'h0, ~s[0]}, {15'h0, ovf});
    end
    // one select high alone still blocks the flag and keeps the paths apart
    rxs = 1'b1;
    txs = 1'b0;
    mode = 2'h1;
    clr;
    repeat (4) @(negedge clk);
    r0 = rxc;
    t0 = txc;
    repeat (64) @(negedge clk);
    chk("rx split", 16'h0002, 16'(rxc - r0));
    chk("tx split", 16'h0008, 16'(txc - t0));
    chk("ovf split", 16'h0000, {15'h0, ovf});
    wrap_up;
  end
endmodule : tb_timer2_flags_baud_select
`default_nettype wire
